//--- tb/dsc_master_model.sv
`timescale 1ns/1ps
module dsc_master_model (
    // Pins driven by the port under test
    input wire logic sdio_o,
    input wire logic sdio_oe,
    input wire logic read_out,
    input wire logic read_out_oe,
    // Serial format currently in force
    input wire logic lsb_first,
    input wire logic sep_pin,
    // Link pins and read results driven by this master
    output logic sclk,
    output logic cs_n,
    output logic io_sync,
    output logic sdio_in,
    output logic [7:0] rd_byte,
    output logic rd_tgl
);
    localparam realtime HALF = 62.5;
    logic m_oe;
    logic m_bit;

    // A released data line floats, so it shows the inverse of the last bit, never a stale copy.
    always_comb sdio_in = m_oe ? m_bit : (sdio_oe ? sdio_o : ~m_bit);

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        io_sync = 1'b0;
        m_oe = 1'b0;
        m_bit = 1'b0;
        rd_byte = 8'h00;
        rd_tgl = 1'b0;
    end

    // Changes only while the clock is low; reads are taken at the rising edge.
    task automatic pulse(input logic b, input logic drv, output logic got);
        m_oe = drv;
        m_bit = b;
        #HALF sclk = 1'b1;
        got = sep_pin ? (read_out_oe ? read_out : 1'bx) : (sdio_oe ? sdio_o : 1'bx);
        #HALF sclk = 1'b0;
    endtask

    task automatic resync();
        logic g;
        cs_n = 1'b0;
        io_sync = 1'b1;
        repeat (3) pulse(1'b0, 1'b1, g);
        io_sync = 1'b0;
        m_oe = 1'b0;
        cs_n = 1'b1;
        #HALF;
    endtask

    task automatic do_byte(input logic [7:0] d, input logic rd, input int nbits,
                           output logic [7:0] q);
        logic g;
        for (int k = 0; k < nbits; k++) begin
            pulse(d[lsb_first ? k : 7 - k], !rd, g);
            q[lsb_first ? k : 7 - k] = g;
        end
    endtask

    // A cut index stops the frame after four bits of that data byte, leaving it unfinished.
    task automatic xfer(input logic [7:0] instr, input logic [47:0] val, input int nb,
                        input int cut, input bit pause);
        logic [7:0] q;
        logic g;
        int j;
        cs_n = 1'b0;
        do_byte(instr, 1'b0, 8, q);
        for (int n = 0; n < nb; n++) begin
            j = lsb_first ? n : nb - 1 - n;
            if (cut == n) begin
                do_byte(val[j*8 +: 8], instr[7], 4, q);
                return;
            end
            do_byte(val[j*8 +: 8], instr[7], 8, q);
            if (instr[7]) begin
                rd_byte = q;
                rd_tgl = ~rd_tgl;
            end
            if (pause && n == 0) begin
                cs_n = 1'b1;
                repeat (4) pulse(1'b1, 1'b1, g);
                cs_n = 1'b0;
            end
        end
        m_oe = 1'b0;
        #HALF cs_n = 1'b1;
        #HALF;
    endtask
endmodule

//--- tb/dsc_serial_port_bench.sv
`timescale 1ns/1ps
module dsc_serial_port_bench;
    import dsc_pkg::*;
    logic mclk, sys_rst, sclk, cs_n, io_sync, sdio_i, sdio_o, sdio_oe, sro, sro_oe;
    logic strobe_i, strobe_o, strobe_oe, halted, lsb, sep, rd_tgl;
    logic [3:0] bank_addr;
    logic [3:0] pd;
    logic [4:0] mult;
    logic [7:0] rd_byte;
    logic [31:0] cw;
    logic [47:0] v0;
    logic [REG_W-1:0] bank_data;
    dsc_ctrl_t cw_out;
    logic [7:0] exp_q[$];
    int n_fail, num_checks, cyc, hi, per, lows;

    dsc_serial_port dsc_serial_port_i (.MCLK_I(mclk), .SYS_RST_I(sys_rst), .SCLK_I(sclk),
        .CS_N_I(cs_n), .IO_SYNC_I(io_sync), .SDIO_I(sdio_i), .SDIO_O(sdio_o),
        .SDIO_OE_O(sdio_oe), .SERIAL_READ_OUT_O(sro), .SERIAL_READ_OUT_OE_O(sro_oe),
        .UPDATE_STROBE_I(strobe_i), .UPDATE_STROBE_O(strobe_o), .UPDATE_STROBE_OE_O(strobe_oe),
        .BANK_ADDR_I(bank_addr), .BANK_DATA_O(bank_data), .CONTROL_WORD_O(cw_out),
        .HALTED_O(halted));

    dsc_master_model dsc_master_model_i (.sdio_o(sdio_o), .sdio_oe(sdio_oe), .read_out(sro),
        .read_out_oe(sro_oe), .lsb_first(lsb), .sep_pin(sep), .sclk(sclk), .cs_n(cs_n),
        .io_sync(io_sync), .sdio_in(sdio_i), .rd_byte(rd_byte), .rd_tgl(rd_tgl));

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        // The model sets its toggle at time zero; that first change is no read.
        #1;
        forever begin
            @(rd_tgl);
            if (exp_q.size() == 0) begin
                check("unexpected read byte", 48'h1, 48'h0);
            end else begin
                check("read byte", rd_byte, exp_q.pop_front());
            end
        end
    end

    always #12.5 mclk = ~mclk;

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            finish_test();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] mk_cw(input logic upd, input logic lsbf, input logic sepf);
        return {3'h0, pd[3], 1'b0, pd[2:0], 1'b0, 1'b1, 1'b1, mult, 7'h00, upd, 6'h00, lsbf, sepf};
    endfunction

    task automatic wr(input logic [3:0] a, input logic [47:0] v, input int nb);
        dsc_master_model_i.xfer({4'h0, a}, v, nb, -1, 1'b0);
    endtask

    task automatic rd(input logic [3:0] a, input logic [47:0] v, input int nb);
        for (int n = 0; n < nb; n++) begin
            exp_q.push_back(v[(lsb ? n : nb - 1 - n) * 8 +: 8]);
        end
        dsc_master_model_i.xfer({4'hF, a}, v, nb, -1, 1'b0);
    endtask

    task automatic ext_update(input int hold);
        repeat (6) @(posedge mclk);
        #2 strobe_i = 1'b0;
        @(posedge mclk);
        #2 strobe_i = 1'b1;
        repeat (hold) @(posedge mclk);
        #2 strobe_i = 1'b0;
        repeat (4) @(posedge mclk);
        #2;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        sys_rst = 1'b1;
        strobe_i = 1'b0;
        bank_addr = 4'h0;
        lsb = 1'b0;
        sep = 1'b0;
        n_fail = 0;
        num_checks = 0;
        cyc = 0;
        void'($urandom(32'h9eb7));
        repeat (4) @(posedge mclk);
        // The link side only leaves reset on link clock edges.
        dsc_master_model_i.resync();
        @(posedge mclk);
        #2 sys_rst = 1'b0;
        dsc_master_model_i.resync();
        check("control word at reset", cw_out, CTRL_RESET);
        check("gain at reset", cw_out.osc_high_gain, 1'b1);
        check("bypass at reset", cw_out.pll_bypass, 1'b1);
        check("halted at reset", halted, 1'b0);
        check("strobe dir at reset", strobe_oe, 1'b0);
        mult = 5'(4 + $urandom % 17);
        pd = 4'($urandom);
        cw = mk_cw(1'b0, 1'b0, 1'b0);
        wr(ADDR_CONTROL_WORD, {16'h0, cw}, 4);
        repeat (8) @(posedge mclk);
        #2 check("bank before update", cw_out, CTRL_RESET);
        strobe_i = 1'b1;
        repeat (8) @(posedge mclk);
        #2 check("bank after strobe", cw_out, cw);
        check("multiplier field", cw_out.ref_mult, mult);
        v0 = 48'($urandom & 32'hFFFF);
        dsc_master_model_i.xfer(8'h00, v0, 2, -1, 1'b1);
        repeat (8) @(posedge mclk);
        #2 check("held strobe", bank_data, 48'h0);
        ext_update(2);
        check("word 0 after update", bank_data, v0);
        rd(ADDR_CONTROL_WORD, {16'h0, cw}, 4);
        rd(4'h0, v0, 2);
        check("read pins idle", {sdio_oe, sro_oe}, 2'b00);
        dsc_master_model_i.xfer(8'h00, ~v0, 2, 0, 1'b0);
        dsc_master_model_i.resync();
        rd(4'h0, v0, 2);
        ext_update(2);
        check("bank after abort", bank_data, v0);
        cw = mk_cw(1'b0, 1'b1, 1'b1);
        wr(ADDR_CONTROL_WORD, {16'h0, cw}, 4);
        ext_update(2);
        // Edges let the new format bits reach the link side.
        dsc_master_model_i.resync();
        lsb = 1'b1;
        sep = 1'b1;
        rd(ADDR_CONTROL_WORD, {16'h0, cw}, 4);
        v0 = 48'($urandom & 32'hFFFF);
        wr(4'h1, v0, 2);
        rd(4'h1, v0, 2);
        wr(ADDR_UPDATE_INTERVAL, 48'hA, 4);
        cw = mk_cw(1'b1, 1'b1, 1'b1);
        wr(ADDR_CONTROL_WORD, {16'h0, cw}, 4);
        ext_update(2);
        bank_addr = ADDR_UPDATE_INTERVAL;
        check("strobe dir internal", strobe_oe, 1'b1);
        lows = 0;
        while (strobe_o !== 1'b0 && lows < 100) begin
            @(negedge mclk);
            lows++;
        end
        while (strobe_o !== 1'b1 && lows < 100) begin
            @(negedge mclk);
            lows++;
        end
        hi = 0;
        per = 0;
        while (strobe_o === 1'b1 && per < 100) begin
            @(negedge mclk);
            hi++;
            per++;
        end
        while (strobe_o !== 1'b1 && per < 100) begin
            @(negedge mclk);
            per++;
        end
        check("strobe pulse width", hi, 8);
        check("update period", per, 20);
        check("interval in bank", bank_data, 48'hA);
        wr(ADDR_UPDATE_INTERVAL, 48'h3, 4);
        repeat (40) @(negedge mclk);
        lows = 0;
        repeat (40) begin
            @(negedge mclk);
            if (strobe_o !== 1'b1) begin
                lows++;
            end
        end
        check("steady strobe", lows, 0);
        check("short interval in bank", bank_data, 48'h3);
        wr(ADDR_CONTROL_WORD, {16'h0, cw | 32'h0800_0000}, 4);
        repeat (40) @(posedge mclk);
        #2 check("halt flag", halted, 1'b1);
        check("pending reads", exp_q.size(), 0);
        finish_test();
    end
endmodule

//--- verilog/dsc_pkg.sv
// Behaviour
// - Select high floats both serial data outputs.
// - Select high freezes transfer; resumes when low.
// - Control bit 0 chooses separate read output.
// - Single-pin mode never drives the read output.
// - Resync aborts transfer; next eight edges instruction.
// - Format bits apply two link clock edges after valid update.
// - Extra edges after data form next instruction.
// - Completed writes survive a resync.
// - Control bit 1 selects LSB-first order.
// - Writes reach buffer; bank copy on system clock.
// - External strobe rising edge triggers one copy.
// - Held strobe never repeats the copy.
// - Internal mode drives eight-cycle strobe pulse out.
// - Interval below five keeps strobe output high.
// - Interval value is half the update period.
// - Control word is 32 bits, address seven.
// - Power-down bits 28, 26:24, default zero.
// - Bit 27 set halts until master reset.
// - Bit 22 oscillator gain, resets to one.
// - Bit 21 multiplier bypass, resets to one.
// - Bits 20:16 hold reference multiplication factor.
// - Instruction: bit 7 read, bits 3:0 address.
// - Sample on rising edge, drive on falling.
// - Data phase length depends on register addressed.
// - Control bit 8 selects internal update source.
package dsc_pkg;
    localparam int NUM_REGS = 12;
    localparam int REG_W = 48;
    localparam logic [3:0] ADDR_LAST = 4'hB;
    localparam logic [3:0] ADDR_UPDATE_INTERVAL = 4'h5;
    localparam logic [3:0] ADDR_CONTROL_WORD = 4'h7;
    localparam logic [7:0] CTRL_BYTE_FIRST = 8'h1D;
    localparam logic [7:0] CTRL_BYTE_LAST = 8'h20;
    localparam logic [2:0] BYTES_SHORT = 3'h2;
    localparam logic [2:0] BYTES_RAMP = 3'h3;
    localparam logic [2:0] BYTES_WORD = 3'h4;
    localparam logic [2:0] BYTES_TUNING = 3'h6;
    localparam logic [31:0] CTRL_RESET = 32'h0060_0000;
    localparam logic [3:0] UPD_PULSE_CYCLES = 4'h8;
    localparam logic [31:0] UPD_STEADY_LIMIT = 32'h0000_0005;
    localparam int MCLK_HZ = 40_000_000;
    localparam int SCLK_MAX_HZ = 10_000_000;

    typedef enum logic {
        PH_INSTR = 1'b0,
        PH_DATA = 1'b1
    } dsc_phase_t;

    typedef struct packed {
        logic [2:0] open_bits;
        logic pd_comparator;
        logic halt_trap;
        logic pd_ctrl_conv;
        logic pd_all_conv;
        logic pd_digital;
        logic rsvd23;
        logic osc_high_gain;
        logic pll_bypass;
        logic [4:0] ref_mult;
        logic [6:0] other_hi;
        logic internal_update;
        logic [5:0] other_lo;
        logic lsb_first;
        logic read_out_en;
    } dsc_ctrl_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [2:0] slot;
        logic [7:0] data;
    } dsc_byte_xfer_t;

    function automatic logic [2:0] reg_bytes(input logic [3:0] addr);
        case (addr)
            4'h2, 4'h3, 4'h4: reg_bytes = BYTES_TUNING;
            4'h5, 4'h7: reg_bytes = BYTES_WORD;
            4'h6: reg_bytes = BYTES_RAMP;
            default: reg_bytes = BYTES_SHORT;
        endcase
    endfunction
endpackage

//--- verilog/dsc_serial_port.sv
`timescale 1ns/1ps
module dsc_serial_port
    import dsc_pkg::*;
(
    // System clock and reset
    input wire logic MCLK_I,
    input wire logic SYS_RST_I,
    // Serial link from the controller
    input wire logic SCLK_I,
    input wire logic CS_N_I,
    input wire logic IO_SYNC_I,
    input wire logic SDIO_I,
    output logic SDIO_O,
    output logic SDIO_OE_O,
    output logic SERIAL_READ_OUT_O,
    output logic SERIAL_READ_OUT_OE_O,
    // Update strobe pin
    input wire logic UPDATE_STROBE_I,
    output logic UPDATE_STROBE_O,
    output logic UPDATE_STROBE_OE_O,
    // Operative register bank
    input wire logic [3:0] BANK_ADDR_I,
    output logic [REG_W-1:0] BANK_DATA_O,
    output dsc_ctrl_t CONTROL_WORD_O,
    output logic HALTED_O
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [2:0] bit_in_byte(input logic [2:0] cnt, input logic lsb);
        bit_in_byte = lsb ? cnt : 3'h7 - cnt;
    endfunction

    function automatic logic [2:0] byte_slot(input logic [2:0] cnt, input logic [2:0] n,
                                             input logic lsb);
        byte_slot = lsb ? cnt : n - 3'h1 - cnt;
    endfunction

    // ----------------------------------------------------------------
    // Link clock domain: reset and format synchronisers
    // ----------------------------------------------------------------
    logic sclk_rst_m_q;
    logic sclk_rst_q;
    logic [1:0] fmt_m_q;
    logic [1:0] fmt_q;
    logic lsb_s;
    logic sdo_s;
    dsc_ctrl_t ctrl;

    // The format bits come from the bank, so they change only on a valid update or a system reset.
    always_ff @(posedge SCLK_I) begin
        sclk_rst_m_q <= SYS_RST_I;
        sclk_rst_q <= sclk_rst_m_q;
        fmt_m_q <= {ctrl.lsb_first, ctrl.read_out_en};
        fmt_q <= fmt_m_q;
    end

    assign lsb_s = fmt_q[1];
    assign sdo_s = fmt_q[0];

    // ----------------------------------------------------------------
    // Link clock domain: serial engine
    // ----------------------------------------------------------------
    dsc_phase_t phase_q, phase_d;
    logic [2:0] bit_cnt_q, bit_cnt_d;
    logic [2:0] byte_cnt_q, byte_cnt_d;
    logic read_q, read_d;
    logic [3:0] addr_q, addr_d;
    logic [7:0] shift_q, shift_d;
    logic [REG_W-1:0] shadow_q [NUM_REGS];
    logic [REG_W-1:0] shadow_d [NUM_REGS];
    dsc_byte_xfer_t xfer_q, xfer_d;
    logic xfer_tgl_q, xfer_tgl_d;
    logic [2:0] wr_slot;

    always_comb begin
        phase_d = phase_q;
        bit_cnt_d = bit_cnt_q;
        byte_cnt_d = byte_cnt_q;
        read_d = read_q;
        addr_d = addr_q;
        shift_d = shift_q;
        shadow_d = shadow_q;
        xfer_d = xfer_q;
        xfer_tgl_d = xfer_tgl_q;
        wr_slot = byte_slot(byte_cnt_q, reg_bytes(addr_q), lsb_s);
        if (IO_SYNC_I) begin
            // Only whole bytes ever leave the assembler, so an abort never writes a partial byte.
            phase_d = PH_INSTR;
            bit_cnt_d = 3'h0;
            byte_cnt_d = 3'h0;
            shift_d = 8'h00;
        end else if (!CS_N_I) begin
            shift_d[bit_in_byte(bit_cnt_q, lsb_s)] = SDIO_I;
            bit_cnt_d = bit_cnt_q + 3'h1;
            if (bit_cnt_q == 3'h7) begin
                if (phase_q == PH_INSTR) begin
                    read_d = shift_d[7];
                    addr_d = shift_d[3:0];
                    phase_d = PH_DATA;
                    byte_cnt_d = 3'h0;
                end else begin
                    if (!read_q && addr_q <= ADDR_LAST) begin
                        shadow_d[addr_q][{wr_slot, 3'h0} +: 8] = shift_d;
                        xfer_d.addr = addr_q;
                        xfer_d.slot = wr_slot;
                        xfer_d.data = shift_d;
                        xfer_tgl_d = !xfer_tgl_q;
                    end
                    if (byte_cnt_q == reg_bytes(addr_q) - 3'h1) begin
                        phase_d = PH_INSTR;
                        byte_cnt_d = 3'h0;
                    end else begin
                        byte_cnt_d = byte_cnt_q + 3'h1;
                    end
                end
            end
        end
    end

    always_ff @(posedge SCLK_I) begin
        if (sclk_rst_q) begin
            phase_q <= PH_INSTR;
            bit_cnt_q <= 3'h0;
            byte_cnt_q <= 3'h0;
            read_q <= 1'b0;
            addr_q <= 4'h0;
            shift_q <= 8'h00;
            for (int i = 0; i < NUM_REGS; i++) begin
                shadow_q[i] <= '0;
            end
            shadow_q[ADDR_CONTROL_WORD] <= {16'h0000, CTRL_RESET};
            xfer_q <= '0;
            xfer_tgl_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            bit_cnt_q <= bit_cnt_d;
            byte_cnt_q <= byte_cnt_d;
            read_q <= read_d;
            addr_q <= addr_d;
            shift_q <= shift_d;
            shadow_q <= shadow_d;
            xfer_q <= xfer_d;
            xfer_tgl_q <= xfer_tgl_d;
        end
    end

    // ----------------------------------------------------------------
    // Link clock domain: read data, launched on the falling edge
    // ----------------------------------------------------------------
    logic rd_bit_q, rd_bit_d;
    logic rd_window;

    assign rd_window = (phase_q == PH_DATA) && read_q;

    always_comb begin
        rd_bit_d = 1'b0;
        if (rd_window && addr_q <= ADDR_LAST) begin
            rd_bit_d = shadow_q[addr_q][{byte_slot(byte_cnt_q, reg_bytes(addr_q), lsb_s),
                                         bit_in_byte(bit_cnt_q, lsb_s)}];
        end
    end

    always_ff @(negedge SCLK_I) begin
        if (sclk_rst_q) begin
            rd_bit_q <= 1'b0;
        end else begin
            rd_bit_q <= rd_bit_d;
        end
    end

    assign SDIO_O = rd_bit_q;
    assign SERIAL_READ_OUT_O = rd_bit_q;
    assign SDIO_OE_O = !CS_N_I && rd_window && !sdo_s;
    assign SERIAL_READ_OUT_OE_O = !CS_N_I && sdo_s;

    // ----------------------------------------------------------------
    // System clock domain: crossings
    // ----------------------------------------------------------------
    logic tgl_m_q;
    logic tgl_s_q;
    logic ud_m_q;
    logic ud_s_q;

    // A byte record stays still for at least eight link edges, far longer than
    // the toggle needs to cross, so the record itself is read without flops.
    always_ff @(posedge MCLK_I) begin
        tgl_m_q <= xfer_tgl_q;
        tgl_s_q <= tgl_m_q;
        ud_m_q <= UPDATE_STROBE_I;
        ud_s_q <= ud_m_q;
    end

    // ----------------------------------------------------------------
    // System clock domain: buffer, bank and update timing
    // ----------------------------------------------------------------
    logic [REG_W-1:0] buf_q [NUM_REGS];
    logic [REG_W-1:0] buf_d [NUM_REGS];
    logic [REG_W-1:0] bank_q [NUM_REGS];
    logic [REG_W-1:0] bank_d [NUM_REGS];
    logic tgl_seen_q, tgl_seen_d;
    logic ud_seen_q, ud_seen_d;
    logic [32:0] rate_cnt_q, rate_cnt_d;
    logic [3:0] pulse_cnt_q, pulse_cnt_d;
    logic strobe_q, strobe_d;
    logic halted_q, halted_d;
    logic [REG_W-1:0] bank_rd_q, bank_rd_d;
    logic [31:0] interval;
    logic [32:0] period;
    logic upd_int;
    logic ext_rise;
    logic rate_hit;
    logic xfer_w;

    assign ctrl = dsc_ctrl_t'(bank_q[ADDR_CONTROL_WORD][31:0]);
    assign interval = bank_q[ADDR_UPDATE_INTERVAL][31:0];
    assign period = {interval, 1'b0};
    assign upd_int = ctrl.internal_update;
    assign ext_rise = ud_s_q && !ud_seen_q;
    assign rate_hit = (rate_cnt_q + 33'h1) >= period;
    assign xfer_w = !halted_q && (upd_int ? rate_hit : ext_rise);

    always_comb begin
        buf_d = buf_q;
        bank_d = bank_q;
        tgl_seen_d = tgl_s_q;
        ud_seen_d = ud_s_q;
        if (tgl_s_q != tgl_seen_q) begin
            buf_d[xfer_q.addr][{xfer_q.slot, 3'h0} +: 8] = xfer_q.data;
        end
        if (xfer_w) begin
            bank_d = buf_q;
        end
        rate_cnt_d = (!upd_int || rate_hit) ? 33'h0 : rate_cnt_q + 33'h1;
        if (xfer_w && upd_int) begin
            pulse_cnt_d = UPD_PULSE_CYCLES;
        end else if (pulse_cnt_q != 4'h0) begin
            pulse_cnt_d = pulse_cnt_q - 4'h1;
        end else begin
            pulse_cnt_d = 4'h0;
        end
        // Short intervals leave no room for the minimum pulse, so the pin sits high.
        strobe_d = (pulse_cnt_d != 4'h0) || (interval < UPD_STEADY_LIMIT);
        halted_d = halted_q || ctrl.halt_trap;
        bank_rd_d = (BANK_ADDR_I <= ADDR_LAST) ? bank_q[BANK_ADDR_I] : '0;
    end

    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                buf_q[i] <= '0;
                bank_q[i] <= '0;
            end
            buf_q[ADDR_CONTROL_WORD] <= {16'h0000, CTRL_RESET};
            bank_q[ADDR_CONTROL_WORD] <= {16'h0000, CTRL_RESET};
            tgl_seen_q <= 1'b0;
            ud_seen_q <= 1'b1;
            rate_cnt_q <= 33'h0;
            pulse_cnt_q <= 4'h0;
            strobe_q <= 1'b0;
            halted_q <= 1'b0;
            bank_rd_q <= '0;
        end else begin
            buf_q <= buf_d;
            bank_q <= bank_d;
            tgl_seen_q <= tgl_seen_d;
            ud_seen_q <= ud_seen_d;
            rate_cnt_q <= rate_cnt_d;
            pulse_cnt_q <= pulse_cnt_d;
            strobe_q <= strobe_d;
            halted_q <= halted_d;
            bank_rd_q <= bank_rd_d;
        end
    end

    assign UPDATE_STROBE_O = strobe_q && upd_int;
    assign UPDATE_STROBE_OE_O = upd_int;
    assign BANK_DATA_O = bank_rd_q;
    assign CONTROL_WORD_O = ctrl;
    assign HALTED_O = halted_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [32:0] gap_q;
    logic prev_int_q;
    logic [31:0] prev_interval_q;
    dsc_ctrl_t buf_ctrl;
    dsc_ctrl_t next_ctrl;

    assign buf_ctrl = dsc_ctrl_t'(buf_q[ADDR_CONTROL_WORD][31:0]);
    assign next_ctrl = dsc_ctrl_t'(bank_d[ADDR_CONTROL_WORD][31:0]);

    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            gap_q <= 33'h0;
            prev_int_q <= 1'b0;
            prev_interval_q <= 32'h0;
        end else begin
            gap_q <= xfer_w ? 33'h0 : gap_q + 33'h1;
            prev_int_q <= xfer_w ? next_ctrl.internal_update : prev_int_q;
            prev_interval_q <= xfer_w ? bank_d[ADDR_UPDATE_INTERVAL][31:0] : prev_interval_q;
        end
    end

    sequence s_ext_rise;
        !UPDATE_STROBE_I ##1 UPDATE_STROBE_I [*2];
    endsequence

    sequence s_last_bit;
        phase_q == PH_DATA && bit_cnt_q == 3'h7 && !CS_N_I && !IO_SYNC_I
            && byte_cnt_q == reg_bytes(addr_q) - 3'h1;
    endsequence

    property p_hiz;
        @(posedge MCLK_I) disable iff (SYS_RST_I)
        CS_N_I |-> (!SDIO_OE_O && !SERIAL_READ_OUT_OE_O);
    endproperty
    a_hiz: assert property (p_hiz) else $error("Data pins driven while deselected.");

    property p_single_pin;
        @(posedge MCLK_I) disable iff (SYS_RST_I)
        (!sdo_s |-> !SERIAL_READ_OUT_OE_O) and (sdo_s |-> !SDIO_OE_O);
    endproperty
    a_single_pin: assert property (p_single_pin) else $error("Wrong pin drives read data.");

    property p_freeze;
        @(posedge SCLK_I) disable iff (sclk_rst_q || SYS_RST_I)
        (CS_N_I && !IO_SYNC_I) |=> ($stable(bit_cnt_q) && $stable(phase_q) && $stable(byte_cnt_q));
    endproperty
    a_freeze: assert property (p_freeze) else $error("Transfer moved while deselected.");

    property p_resync;
        @(posedge SCLK_I) disable iff (sclk_rst_q || SYS_RST_I)
        IO_SYNC_I |=> (phase_q == PH_INSTR && bit_cnt_q == 3'h0 && shift_q == 8'h00);
    endproperty
    a_resync: assert property (p_resync) else $error("Resync left the engine mid-transfer.");

    property p_no_fragment;
        @(posedge SCLK_I) disable iff (sclk_rst_q || SYS_RST_I)
        IO_SYNC_I |=> $stable(xfer_tgl_q);
    endproperty
    a_no_fragment: assert property (p_no_fragment) else $error("Byte written during resync.");

    property p_frame_end;
        @(posedge SCLK_I) disable iff (sclk_rst_q || SYS_RST_I)
        s_last_bit |=> (phase_q == PH_INSTR && bit_cnt_q == 3'h0);
    endproperty
    a_frame_end: assert property (p_frame_end) else $error("Data phase overran its length.");

    property p_bank_copy;
        @(posedge MCLK_I) disable iff (SYS_RST_I)
        xfer_w |=> (bank_q[ADDR_CONTROL_WORD] == $past(buf_q[ADDR_CONTROL_WORD]));
    endproperty
    a_bank_copy: assert property (p_bank_copy) else $error("Bank did not take the buffer.");

    property p_ext_update;
        @(posedge MCLK_I) disable iff (SYS_RST_I)
        (s_ext_rise and (!upd_int && !halted_q) [*3]) |-> ##[0:1] xfer_w;
    endproperty
    a_ext_update: assert property (p_ext_update) else $error("Strobe edge gave no transfer.");

    property p_no_repeat;
        @(posedge MCLK_I) disable iff (SYS_RST_I)
        (xfer_w && !upd_int) |=> !xfer_w;
    endproperty
    a_no_repeat: assert property (p_no_repeat) else $error("External transfer repeated.");

    property p_int_pulse;
        @(posedge MCLK_I) disable iff (SYS_RST_I)
        (xfer_w && upd_int && buf_ctrl.internal_update) |=> UPDATE_STROBE_O [*8];
    endproperty
    a_int_pulse: assert property (p_int_pulse) else $error("Update pulse shorter than eight.");

    property p_steady;
        @(posedge MCLK_I) disable iff (SYS_RST_I)
        (upd_int && $stable(interval) && interval < UPD_STEADY_LIMIT) |=> UPDATE_STROBE_O;
    endproperty
    a_steady: assert property (p_steady) else $error("Strobe low with short interval.");

    property p_int_rate;
        @(posedge MCLK_I) disable iff (SYS_RST_I)
        (xfer_w && upd_int && prev_int_q && interval == prev_interval_q && interval != 32'h0)
            |-> (gap_q + 33'h1 == period);
    endproperty
    a_int_rate: assert property (p_int_rate) else $error("Internal update period wrong.");

    property p_halt;
        @(posedge MCLK_I) disable iff (SYS_RST_I)
        ctrl.halt_trap |=> (HALTED_O && !xfer_w) [*3];
    endproperty
    a_halt: assert property (p_halt) else $error("Halt bit did not stop updates.");

    property p_reset_ctrl;
        @(posedge MCLK_I) disable iff (SYS_RST_I)
        $fell(SYS_RST_I) |-> (CONTROL_WORD_O == CTRL_RESET && !HALTED_O);
    endproperty
    a_reset_ctrl: assert property (p_reset_ctrl) else $error("Control word reset wrong.");

endmodule
